// >>> legacy_timer_map.vh
// register addresses, field positions, reset values and counts of the
// two-timer block; definitions only, included by the timer files
`ifndef LEGACY_TIMER_MAP_VH
`define LEGACY_TIMER_MAP_VH

// special function register addresses
`define ADDR_TIMER_CONTROL  8'h88
`define ADDR_TIMER_MODE     8'h89
`define ADDR_LOW_BYTE_A     8'h8a
`define ADDR_LOW_BYTE_B     8'h8b
`define ADDR_HIGH_BYTE_A    8'h8c
`define ADDR_HIGH_BYTE_B    8'h8d
`define ADDR_TICK_DIVIDER   8'h8e

// timer_control_reg fields
`define CTL_OVF_B           7
`define CTL_RUN_B           6
`define CTL_OVF_A           5
`define CTL_RUN_A           4

// timer_mode_reg fields (timer b in the upper nibble)
`define MOD_GATE_B          7
`define MOD_SRC_B           6
`define MOD_MODE_B_HI       5
`define MOD_MODE_B_LO       4
`define MOD_GATE_A          3
`define MOD_SRC_A           2
`define MOD_MODE_A_HI       1
`define MOD_MODE_A_LO       0

// tick_divider_reg fields
`define DIV_SPARE           5
`define DIV_TICK_B          4
`define DIV_TICK_A          3

// mode_field encodings
`define MODE_13BIT          2'h0
`define MODE_16BIT          2'h1
`define MODE_RELOAD8        2'h2
`define MODE_SPLIT          2'h3

// reset values
`define RST_CONTROL         8'h00
`define RST_MODE            8'h00
`define RST_DIVIDER         8'h00
`define RST_COUNT           8'h00

// system clocks per slow tick
`define TICK_DIVIDE         4'hc

`endif

// >>> fall_detect.v
// synchronises one pin into sys_clk and reports its level and falling edges
// assumes the pin is asynchronous and holds each level at least two clocks
module fall_detect (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // pin side
  input  wire pin_in,
  // synchronised side
  output wire level,
  output wire fall
);

  reg meta_q;   // first stage, read by stage two only
  reg sync_q;   // second stage, safe to use
  reg prev_q;   // previous safe level

  // two flops then one history flop
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;  // high to low seen

endmodule // fall_detect

// >>> tick_prescaler.v
// makes a one-cycle enable every twelfth system clock
// assumes one clock domain and a synchronous active-high reset
`include "legacy_timer_map.vh"
module tick_prescaler (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // slow tick
  output reg  tick12
);

  reg [3:0] cnt_q;  // cycles since last tick

  // free-running divide by twelve
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      tick12 <= 1'b0;
    end else if (cnt_q == (`TICK_DIVIDE - 4'h1)) begin
      cnt_q  <= 4'h0;
      tick12 <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 4'h1;
      tick12 <= 1'b0;
    end
  end

endmodule // tick_prescaler

// >>> dual_timer.v
// two legacy counter/timers reached as special function registers
// assumes a cpu sfr port on sys_clk and asynchronous count and gate pins
`include "legacy_timer_map.vh"
module dual_timer (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // sfr port from the cpu
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  // interrupt vector acknowledges
  input  wire       vector_ack_a,
  input  wire       vector_ack_b,
  // pins
  input  wire       count_pin_a,
  input  wire       count_pin_b,
  input  wire       gate_pin_a,
  input  wire       gate_pin_b,
  // status outputs
  output reg        overflow_flag_a,
  output reg        overflow_flag_b,
  output reg        baud_tick
);

  // software visible state
  reg [7:0] timer_control_q;   // run bits; flags held separately
  reg [7:0] timer_mode_q;      // both mode nibbles
  reg [7:0] tick_divider_q;    // tick_divide_bits
  reg [7:0] low_byte_a_q;      // timer a low byte
  reg [7:0] high_byte_a_q;     // timer a high byte
  reg [7:0] low_byte_b_q;      // timer b low byte
  reg [7:0] high_byte_b_q;     // timer b high byte

  // next values
  reg [7:0] low_byte_a_d;
  reg [7:0] high_byte_a_d;
  reg [7:0] low_byte_b_d;
  reg [7:0] high_byte_b_d;
  reg       ovf_a_hit;         // timer a overflow this cycle
  reg       ovf_b_hit;         // timer b overflow this cycle
  reg       ovf_high_a_hit;    // split high byte overflow
  reg       ovf_flag_a_d;
  reg       ovf_flag_b_d;
  reg [7:0] rdata_d;

  // synchronised pin information
  wire      fall_a;            // count_pin_a falling edge
  wire      fall_b;            // count_pin_b falling edge
  wire      gate_level_a;      // gate_pin_a level
  wire      gate_level_b;      // gate_pin_b level
  wire      tick12;            // clock divided by twelve

  // decoded control fields
  wire [1:0] mode_field_a = timer_mode_q[`MOD_MODE_A_HI:`MOD_MODE_A_LO];
  wire [1:0] mode_field_b = timer_mode_q[`MOD_MODE_B_HI:`MOD_MODE_B_LO];
  wire       gate_select_a   = timer_mode_q[`MOD_GATE_A];
  wire       gate_select_b   = timer_mode_q[`MOD_GATE_B];
  wire       source_select_a = timer_mode_q[`MOD_SRC_A];
  wire       source_select_b = timer_mode_q[`MOD_SRC_B];
  wire       run_bit_a       = timer_control_q[`CTL_RUN_A];
  wire       run_bit_b       = timer_control_q[`CTL_RUN_B];
  wire       split_a         = (mode_field_a == `MODE_SPLIT);

  // write strobes per register
  wire wr_ctl  = sfr_wr & (sfr_addr == `ADDR_TIMER_CONTROL);
  wire wr_mod  = sfr_wr & (sfr_addr == `ADDR_TIMER_MODE);
  wire wr_div  = sfr_wr & (sfr_addr == `ADDR_TICK_DIVIDER);
  wire wr_tla  = sfr_wr & (sfr_addr == `ADDR_LOW_BYTE_A);
  wire wr_tha  = sfr_wr & (sfr_addr == `ADDR_HIGH_BYTE_A);
  wire wr_tlb  = sfr_wr & (sfr_addr == `ADDR_LOW_BYTE_B);
  wire wr_thb  = sfr_wr & (sfr_addr == `ADDR_HIGH_BYTE_B);

  // pin synchronisers; two flops ahead of any logic
  fall_detect u_count_a (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (count_pin_a),
    .level   (),
    .fall    (fall_a)
  );

  fall_detect u_count_b (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (count_pin_b),
    .level   (),
    .fall    (fall_b)
  );

  fall_detect u_gate_a (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (gate_pin_a),
    .level   (gate_level_a),
    .fall    ()
  );

  fall_detect u_gate_b (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (gate_pin_b),
    .level   (gate_level_b),
    .fall    ()
  );

  // shared divide-by-twelve tick
  tick_prescaler u_prescale (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick12  (tick12)
  );

  // timer tick: full clock or one in twelve
  function tick_sel;
    input fast;
    input slow_tick;
    begin
      tick_sel = fast | slow_tick;
    end
  endfunction

  // one counting step of a timer in modes 0 to 2
  // returns {overflow, high, low}
  function [16:0] step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [13:0] c13;
    reg   [16:0] c16;
    reg   [8:0]  c8;
    begin
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8  = {1'b0, lo} + 9'h001;
      case (mode)
        `MODE_13BIT: begin
          // low byte upper bits left untouched
          step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        end
        `MODE_16BIT: begin
          step = c16;
        end
        `MODE_RELOAD8: begin
          // reload from high byte, high byte unchanged
          step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
        end
        default: begin
          step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // source and gate qualification of timer a, plus the tick and gate terms of timer b
  wire tick_a   = tick_sel(tick_divider_q[`DIV_TICK_A], tick12);
  wire tick_b   = tick_sel(tick_divider_q[`DIV_TICK_B], tick12);
  wire gate_ok_a = ~gate_select_a | gate_level_a;
  wire gate_ok_b = ~gate_select_b | gate_level_b;
  wire src_ev_a  = source_select_a ? fall_a : tick_a;
  wire en_a      = run_bit_a & gate_ok_a & src_ev_a;
  // timer b: pins ignored while timer a is split
  wire src_ev_b  = (source_select_b & ~split_a) ? fall_b : tick_b;
  // while split the run bit belongs to the high byte of timer a
  wire run_b_eff = split_a ? 1'b1 : (run_bit_b & gate_ok_b);
  wire en_b      = (mode_field_b != `MODE_SPLIT) & run_b_eff & src_ev_b;
  // split high byte: ticks only, run by run_bit_b
  wire en_high_a = split_a & run_bit_b & tick_a;

  // counter next state; a cpu write to a byte wins over counting
  always @* begin
    low_byte_a_d   = low_byte_a_q;
    high_byte_a_d  = high_byte_a_q;
    low_byte_b_d   = low_byte_b_q;
    high_byte_b_d  = high_byte_b_q;
    ovf_a_hit      = 1'b0;
    ovf_b_hit      = 1'b0;
    ovf_high_a_hit = 1'b0;
    // timer a
    if (split_a) begin
      // low byte as its own 8-bit counter
      if (en_a) begin
        {ovf_a_hit, low_byte_a_d} = {1'b0, low_byte_a_q} + 9'h001;
      end
      // high byte as a tick-only 8-bit timer
      if (en_high_a) begin
        {ovf_high_a_hit, high_byte_a_d} = {1'b0, high_byte_a_q} + 9'h001;
      end
    end else if (en_a) begin
      {ovf_a_hit, high_byte_a_d, low_byte_a_d} =
        step(mode_field_a, high_byte_a_q, low_byte_a_q);
    end
    // timer b, modes 0 to 2 only
    if (en_b) begin
      {ovf_b_hit, high_byte_b_d, low_byte_b_d} =
        step(mode_field_b, high_byte_b_q, low_byte_b_q);
    end
    // software writes preload; run bit leaves counts alone
    if (wr_tla) begin
      low_byte_a_d = sfr_wdata;
    end
    if (wr_tha) begin
      high_byte_a_d = sfr_wdata;
    end
    if (wr_tlb) begin
      low_byte_b_d = sfr_wdata;
    end
    if (wr_thb) begin
      high_byte_b_d = sfr_wdata;
    end
  end

  // overflow flags: write, then vector clear, then hardware set wins
  always @* begin
    ovf_flag_a_d = overflow_flag_a;
    ovf_flag_b_d = overflow_flag_b;
    if (wr_ctl) begin
      ovf_flag_a_d = sfr_wdata[`CTL_OVF_A];
      ovf_flag_b_d = sfr_wdata[`CTL_OVF_B];
    end
    if (vector_ack_a) begin
      ovf_flag_a_d = 1'b0;
    end
    if (vector_ack_b) begin
      ovf_flag_b_d = 1'b0;
    end
    if (ovf_a_hit) begin
      ovf_flag_a_d = 1'b1;
    end
    // split: high byte of a drives flag b, timer b never does
    if (split_a ? ovf_high_a_hit : ovf_b_hit) begin
      ovf_flag_b_d = 1'b1;
    end
  end

  // read data mux; unused bits read zero
  always @* begin
    case (sfr_addr)
      `ADDR_TIMER_CONTROL: begin
        rdata_d = {overflow_flag_b, run_bit_b, overflow_flag_a, run_bit_a, 4'h0};
      end
      `ADDR_TIMER_MODE: begin
        rdata_d = timer_mode_q;
      end
      `ADDR_TICK_DIVIDER: begin
        rdata_d = {2'h0, tick_divider_q[5:3], 3'h0};
      end
      `ADDR_LOW_BYTE_A: begin
        rdata_d = low_byte_a_q;
      end
      `ADDR_HIGH_BYTE_A: begin
        rdata_d = high_byte_a_q;
      end
      `ADDR_LOW_BYTE_B: begin
        rdata_d = low_byte_b_q;
      end
      `ADDR_HIGH_BYTE_B: begin
        rdata_d = high_byte_b_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // configuration registers
  always @(posedge sys_clk) begin
    if (rst) begin
      timer_control_q <= `RST_CONTROL;
      timer_mode_q    <= `RST_MODE;
      tick_divider_q  <= `RST_DIVIDER;
    end else begin
      if (wr_ctl) begin
        // only the run bits live here
        timer_control_q <= {1'b0, sfr_wdata[`CTL_RUN_B], 1'b0, sfr_wdata[`CTL_RUN_A], 4'h0};
      end
      if (wr_mod) begin
        timer_mode_q <= sfr_wdata;
      end
      if (wr_div) begin
        tick_divider_q <= {2'h0, sfr_wdata[5:3], 3'h0};
      end
    end
  end

  // count registers and flags
  always @(posedge sys_clk) begin
    if (rst) begin
      low_byte_a_q    <= `RST_COUNT;
      high_byte_a_q   <= `RST_COUNT;
      low_byte_b_q    <= `RST_COUNT;
      high_byte_b_q   <= `RST_COUNT;
      overflow_flag_a <= 1'b0;
      overflow_flag_b <= 1'b0;
      baud_tick       <= 1'b0;
    end else begin
      low_byte_a_q    <= low_byte_a_d;
      high_byte_a_q   <= high_byte_a_d;
      low_byte_b_q    <= low_byte_b_d;
      high_byte_b_q   <= high_byte_b_d;
      overflow_flag_a <= ovf_flag_a_d;
      overflow_flag_b <= ovf_flag_b_d;
      // timer b overflow stays usable as a rate source
      baud_tick       <= ovf_b_hit;
    end
  end

  // registered read port
  always @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_d;
    end
  end

endmodule // dual_timer

// >>> dual_timer_asserts.sv
// checker for the two-timer block: control reads, flags, run and stop
// assumes it is bound to dual_timer and sees only that module's ports
`include "legacy_timer_map.vh"
module dual_timer_asserts (
  // clock and reset
  input logic       sys_clk,
  input logic       rst,
  // sfr port
  input logic [7:0] sfr_addr,
  input logic       sfr_wr,
  input logic [7:0] sfr_wdata,
  input logic       sfr_rd,
  input logic [7:0] sfr_rdata,
  // acknowledges and status
  input logic       vector_ack_a,
  input logic       vector_ack_b,
  input logic       overflow_flag_a,
  input logic       overflow_flag_b,
  input logic       baud_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] mode_q;  // copy of the mode register
  logic [1:0] run_q;   // copy of run bits {b, a}
  wire ctl_wr = sfr_wr && sfr_addr == `ADDR_TIMER_CONTROL;
  wire mode_wr = sfr_wr && sfr_addr == `ADDR_TIMER_MODE;
  wire [3:0] ctl_view = {overflow_flag_b, run_q[1], overflow_flag_a, run_q[0]};
  wire b_off = mode_q[5:4] == 2'h3;  // timer b parked in mode three
  // follow cpu writes; hardware never touches run or mode bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= 8'h00;
      run_q  <= 2'h0;
    end else begin
      if (mode_wr) mode_q <= sfr_wdata;
      if (ctl_wr) run_q <= {sfr_wdata[6], sfr_wdata[4]};
    end
  end
  property p_ctl_read;
    sfr_rd && sfr_addr == `ADDR_TIMER_CONTROL |=> sfr_rdata == {$past(ctl_view), 4'h0};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");
  property p_flag_wr;
    ctl_wr && sfr_wdata[5] && !vector_ack_a |=> overflow_flag_a;
  endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("flag a not written");
  property p_hold_a;
    !run_q[0] && !ctl_wr |=> !$rose(overflow_flag_a);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("flag a rose while stopped");
  property p_hold_b;
    !run_q[1] && !ctl_wr |=> !$rose(overflow_flag_b);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("flag b rose while stopped");
  property p_ack_a;
    vector_ack_a && !run_q[0] && !ctl_wr |=> !overflow_flag_a;
  endproperty
  a_ack_a: assert property (p_ack_a) else $error("flag a kept after vector");
  property p_ack_b;
    vector_ack_b && !run_q[1] && !ctl_wr |=> !overflow_flag_b;
  endproperty
  a_ack_b: assert property (p_ack_b) else $error("flag b kept after vector");
  property p_baud_flag;
    baud_tick && mode_q[1:0] != 2'h3 && !b_off |-> overflow_flag_b;
  endproperty
  a_baud_flag: assert property (p_baud_flag) else $error("timer b wrap without flag");
  property p_b_stop;
    (b_off && !mode_wr) ##1 b_off |=> !baud_tick;
  endproperty
  a_b_stop: assert property (p_b_stop) else $error("timer b moved in mode three");
  c_ovf_a: cover property ($rose(overflow_flag_a));
  c_baud: cover property (baud_tick);
  c_ack: cover property (vector_ack_a && overflow_flag_a);
endmodule // dual_timer_asserts

bind dual_timer dual_timer_asserts i_chk (
  .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b),
  .overflow_flag_a(overflow_flag_a), .overflow_flag_b(overflow_flag_b),
  .baud_tick(baud_tick)
);

// >>> pin_source.sv
// far side of the timer block: count pins and gate pins
// assumes the bench calls its tasks; levels change on the falling clock
module pin_source (
  // clock
  input  logic sys_clk,
  // pins toward the timer block
  output logic count_pin_a,
  output logic count_pin_b,
  output logic gate_pin_a,
  output logic gate_pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins idle high so no edge is seen before a burst
  initial begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    gate_pin_a  = 1'b1;
    gate_pin_b  = 1'b1;
  end
  // n falling edges on one pin, every level held hold clocks (two or more)
  task automatic pulse(input logic sel, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(negedge sys_clk);
      if (sel) count_pin_b = 1'b0;
      else count_pin_a = 1'b0;
      repeat (hold) @(negedge sys_clk);
      if (sel) count_pin_b = 1'b1;
      else count_pin_a = 1'b1;
    end
  endtask
  // set one gate pin level
  task automatic gate(input logic sel, input logic lvl);
    @(negedge sys_clk);
    if (sel) gate_pin_b = lvl;
    else gate_pin_a = lvl;
  endtask
endmodule // pin_source

// >>> testbench.sv
// self-checking bench for the two-timer block over its sfr port
// assumes dual_timer, its map header, pin_source and the bound checker
`include "legacy_timer_map.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;  // 10 MHz system clock
  logic       rst = 1'b1;      // held for ten clocks
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       vector_ack_a = 1'b0;
  logic       vector_ack_b = 1'b0;
  logic       count_pin_a, count_pin_b, gate_pin_a, gate_pin_b;
  logic       flag_a, flag_b, baud_tick;
  logic [7:0] rv;            // last read value
  int         failures = 0;
  int         n_tests = 0;
  int         baud_cnt = 0;  // baud pulses seen
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (baud_tick === 1'b1) baud_cnt++;
  dual_timer i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b),
    .count_pin_a(count_pin_a), .count_pin_b(count_pin_b), .gate_pin_a(gate_pin_a),
    .gate_pin_b(gate_pin_b), .overflow_flag_a(flag_a), .overflow_flag_b(flag_b),
    .baud_tick(baud_tick));
  pin_source i_pins (.sys_clk(sys_clk), .count_pin_a(count_pin_a),
    .count_pin_b(count_pin_b), .gate_pin_a(gate_pin_a), .gate_pin_b(gate_pin_b));
  // one write, strobe high for a single clock
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  // one read; data stands from the clock after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    rv = sfr_rdata;
  endtask
  // preload a timer, run it gap+2 clocks (pins burst first), compare
  task automatic run_case(input logic t, input logic [7:0] md, dv, lo, hi, elo, ehi,
                          input logic ef, input int np, input int gap);
    logic [7:0] mask;
    mask = ((t ? md[5:4] : md[1:0]) == 2'h0) ? 8'h1f : 8'hff;
    wr(`ADDR_TIMER_MODE, md);
    wr(`ADDR_TICK_DIVIDER, dv);
    wr(t ? `ADDR_LOW_BYTE_B : `ADDR_LOW_BYTE_A, lo);
    wr(t ? `ADDR_HIGH_BYTE_B : `ADDR_HIGH_BYTE_A, hi);
    wr(`ADDR_TIMER_CONTROL, t ? 8'h40 : 8'h10);
    if (np > 0) i_pins.pulse(t, np, 2);
    repeat (gap) @(negedge sys_clk);
    `CHK(t ? flag_b : flag_a, ef)
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rd(t ? `ADDR_LOW_BYTE_B : `ADDR_LOW_BYTE_A);
    `CHK(rv & mask, elo)
    rd(t ? `ADDR_HIGH_BYTE_B : `ADDR_HIGH_BYTE_A);
    `CHK(rv, ehi)
  endtask
  // pulse one vector acknowledge
  task automatic ack(input logic t);
    @(negedge sys_clk);
    if (t) vector_ack_b = 1'b1;
    else vector_ack_a = 1'b1;
    @(negedge sys_clk);
    vector_ack_a = 1'b0;
    vector_ack_b = 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog on the whole run
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 8'h88; a <= 8'h90; a++) begin
      rd(a[7:0]);
      `CHK(rv, 8'h00)
    end
    wr(8'h90, 8'h5a);
    rd(8'h90);
    `CHK(rv, 8'h00)
    wr(`ADDR_TICK_DIVIDER, 8'hff);
    rd(`ADDR_TICK_DIVIDER);
    `CHK(rv, 8'h38)
    wr(`ADDR_TIMER_MODE, 8'ha5);
    rd(`ADDR_TIMER_MODE);
    `CHK(rv, 8'ha5)
    run_case(0, 8'h00, 8'h08, 8'hff, 8'hff, 8'h02, 8'h00, 1, 0, 1);
    run_case(0, 8'h01, 8'h08, 8'hff, 8'hff, 8'h02, 8'h00, 1, 0, 1);
    run_case(0, 8'h02, 8'h08, 8'hff, 8'h80, 8'h82, 8'h80, 1, 0, 1);
    run_case(1, 8'h00, 8'h10, 8'hff, 8'hff, 8'h02, 8'h00, 1, 0, 1);
    run_case(1, 8'h10, 8'h10, 8'hff, 8'hff, 8'h02, 8'h00, 1, 0, 1);
    run_case(1, 8'h20, 8'h10, 8'hff, 8'h80, 8'h82, 8'h80, 1, 0, 1);
    run_case(0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 0, 0, 118);
    run_case(1, 8'h10, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 0, 0, 118);
    run_case(0, 8'h01, 8'h08, 8'h00, 8'h00, 8'h78, 8'h00, 0, 0, 118);
    run_case(0, 8'h05, 8'h08, 8'h00, 8'h00, 8'h05, 8'h00, 0, 5, 8);
    run_case(1, 8'h50, 8'h10, 8'h00, 8'h00, 8'h05, 8'h00, 0, 5, 8);
    i_pins.gate(0, 1'b0);
    run_case(0, 8'h09, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 1);
    i_pins.gate(0, 1'b1);
    run_case(0, 8'h09, 8'h08, 8'h00, 8'h00, 8'h03, 8'h00, 0, 0, 1);
    // timer b gated by its own pin
    i_pins.gate(1, 1'b0);
    run_case(1, 8'h90, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 1);
    i_pins.gate(1, 1'b1);
    run_case(1, 8'h90, 8'h10, 8'h00, 8'h00, 8'h03, 8'h00, 0, 0, 1);
    // split: low byte under run_a, high byte under run_b, timer b parked
    wr(`ADDR_TIMER_MODE, 8'h33);
    wr(`ADDR_LOW_BYTE_A, 8'hfe);
    wr(`ADDR_HIGH_BYTE_A, 8'hff);
    wr(`ADDR_LOW_BYTE_B, 8'hff);
    wr(`ADDR_HIGH_BYTE_B, 8'hff);
    wr(`ADDR_TICK_DIVIDER, 8'h18);
    wr(`ADDR_TIMER_CONTROL, 8'h50);
    @(negedge sys_clk);
    `CHK({flag_b, flag_a}, 2'b10)
    @(negedge sys_clk);
    `CHK(flag_a, 1'b1)
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rd(`ADDR_HIGH_BYTE_A);
    `CHK(rv, 8'h03)
    rd(`ADDR_LOW_BYTE_A);
    `CHK(rv, 8'h02)
    rd(`ADDR_LOW_BYTE_B);
    `CHK(rv, 8'hff)
    // timer b runs on ticks, ignores its pin and never flags
    baud_cnt = 0;
    wr(`ADDR_TIMER_MODE, 8'h53);
    i_pins.pulse(1, 3, 2);
    wr(`ADDR_TIMER_MODE, 8'h33);
    rd(`ADDR_LOW_BYTE_B);
    `CHK(rv, 8'h0d)
    rd(`ADDR_TIMER_CONTROL);
    `CHK(rv, 8'h00)
    `CHK(baud_cnt, 1)
    // flags written by software, cleared by the vector
    wr(`ADDR_TIMER_CONTROL, 8'ha0);
    ack(0);
    rd(`ADDR_TIMER_CONTROL);
    `CHK(rv, 8'h80)
    ack(1);
    rd(`ADDR_TIMER_CONTROL);
    `CHK(rv, 8'h00)
    summarize();
  end
endmodule // testbench
